// ### design/cfgrb_params.svh
// Offsets, field positions, masks and frame counts of the configuration register bank.
`ifndef CFGRB_PARAMS_SVH
`define CFGRB_PARAMS_SVH
`define CFGRB_ADDR_AMP1 7'h01
`define CFGRB_ADDR_AMP2 7'h02
`define CFGRB_ADDR_MOD 7'h03
`define CFGRB_ADDR_PWR 7'h04
`define CFGRB_RESET_VAL 8'h00
`define CFGRB_MASK_AMP1 8'hFF
`define CFGRB_MASK_AMP2 8'hF7
`define CFGRB_MASK_MOD 8'hF0
`define CFGRB_MASK_PWR 8'hBF
`define CFGRB_AMP_SLEEP_BIT 7
`define CFGRB_AMP_PRECISE_BIT 6
`define CFGRB_SEL_HI 5
`define CFGRB_SEL_LO 4
`define CFGRB_GUARD_OFF_BIT 3
`define CFGRB_SCALE_HI 2
`define CFGRB_SCALE_LO 0
`define CFGRB_SCALE_RESERVED 3'h7
`define CFGRB_SEL_TERM 2'h0
`define CFGRB_MOD_SHIFT_OFF_BIT 7
`define CFGRB_MOD_PRECISE_BIT 6
`define CFGRB_MOD2_SLEEP_BIT 5
`define CFGRB_MOD1_SLEEP_BIT 4
`define CFGRB_PWR_MOD_BIAS_BIT 7
`define CFGRB_PWR_I1_HI 5
`define CFGRB_PWR_I1_LO 4
`define CFGRB_PWR_COARSE_BIT 3
`define CFGRB_PWR_TAIL_BIT 2
`define CFGRB_PWR_I5_HI 1
`define CFGRB_PWR_I5_LO 0
`define CFGRB_CMD_READ_BIT 7
`define CFGRB_FRAME_CMD_LAST 4'h7
`define CFGRB_FRAME_FIRST_DATA 4'h8
`define CFGRB_FRAME_LAST 4'hF
`endif

// ### design/cfgrb_pkg.sv
// Types shared by the configuration register bank modules.
package cfgrb_pkg;
    typedef logic [7:0] cfgrb_byte_t;
    typedef logic [6:0] cfgrb_addr_t;
    typedef enum logic [1:0] {
        CFGRB_PH_CMD,
        CFGRB_PH_DATA,
        CFGRB_PH_DONE
    } cfgrb_phase_t;
endpackage

// ### design/cfgrb_pin_sync.sv
// Three-stage synchroniser for the serial port pins with agreement filter.
`timescale 1ns/100ps
module cfgrb_pin_sync import cfgrb_pkg::*; #(
    parameter logic [2:0] RESET_LEVEL = 3'h0
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Pins and clean levels
    input wire logic [2:0] pin_i,
    output logic [2:0] level_o
);
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic lvl_r;
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    s1_r <= RESET_LEVEL[g];
                    s2_r <= RESET_LEVEL[g];
                    s3_r <= RESET_LEVEL[g];
                    lvl_r <= RESET_LEVEL[g];
                end else begin
                    s1_r <= pin_i[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    // A change counts only once the second and third stages agree.
                    if (s2_r == s3_r) begin
                        lvl_r <= s3_r;
                    end
                end
            end
            assign level_o[g] = lvl_r;
        end
    endgenerate
endmodule

// ### design/cfgrb_spi_frame.sv
// Serial frame engine: command byte then one data byte, mode 0, MSB first.
`timescale 1ns/100ps
`include "cfgrb_params.svh"
module cfgrb_spi_frame import cfgrb_pkg::*; (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Synchronised pin levels
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    // Register side
    input wire cfgrb_byte_t rd_data_i,
    output cfgrb_addr_t addr_o,
    output logic wr_stb_o,
    output cfgrb_byte_t wr_data_o,
    // Serial output
    output logic sdo_o,
    output logic sdo_oe_o
);
    logic sclk_d_r;
    logic [3:0] cnt_r;
    cfgrb_phase_t phase_r;
    cfgrb_byte_t shift_r;
    cfgrb_byte_t tx_r;
    logic is_read_r;
    logic rise;
    logic fall;

    assign rise = sclk_i & ~sclk_d_r;
    assign fall = ~sclk_i & sclk_d_r;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 4'h0;
            phase_r <= CFGRB_PH_CMD;
            shift_r <= 8'h00;
            is_read_r <= 1'b0;
            addr_o <= 7'h00;
        end else if (cs_n_i) begin
            cnt_r <= 4'h0;
            phase_r <= CFGRB_PH_CMD;
        end else if (rise) begin
            shift_r <= {shift_r[6:0], sdi_i};
            case (phase_r)
                CFGRB_PH_CMD: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `CFGRB_FRAME_CMD_LAST) begin
                        is_read_r <= shift_r[`CFGRB_CMD_READ_BIT - 1];
                        addr_o <= {shift_r[5:0], sdi_i};
                        phase_r <= CFGRB_PH_DATA;
                    end
                end
                CFGRB_PH_DATA: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `CFGRB_FRAME_LAST) begin
                        phase_r <= CFGRB_PH_DONE;
                    end
                end
                default: begin
                    cnt_r <= cnt_r;
                end
            endcase
        end
    end

    // Bits beyond the sixteenth are ignored, so a long frame writes only once.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_stb_o <= 1'b0;
            wr_data_o <= 8'h00;
        end else begin
            wr_stb_o <= ~cs_n_i & rise & (phase_r == CFGRB_PH_DATA) & (cnt_r == `CFGRB_FRAME_LAST) & ~is_read_r;
            if (~cs_n_i & rise & (phase_r == CFGRB_PH_DATA) & (cnt_r == `CFGRB_FRAME_LAST)) begin
                wr_data_o <= {shift_r[6:0], sdi_i};
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
            tx_r <= 8'h00;
        end else if (cs_n_i) begin
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else begin
            sdo_oe_o <= 1'b1;
            if (fall & (phase_r == CFGRB_PH_DATA) & is_read_r) begin
                if (cnt_r == `CFGRB_FRAME_FIRST_DATA) begin
                    sdo_o <= rd_data_i[7];
                    tx_r <= rd_data_i;
                end else begin
                    sdo_o <= tx_r[~cnt_r[2:0]];
                end
            end
        end
    end
endmodule

// ### design/cfgrb_top.sv
// Configuration register bank for the dual amplifier and modulator front end.
// Notes on behaviour
// - Amplifier one power down bit 7: one sleeps, zero runs.
// - Amplifier one bit 6 enables high precision mode.
// - Amplifier one bits 5:4 pick both inputs, A, B or termination.
// - Amplifier one bit 3 is guard off: zero enables guard drive.
// - Amplifier one bits 2:0 give gain 1x to 64x; 111 reserved.
// - Amplifier two bit 7 power down, bit 6 high precision.
// - Amplifier two bits 5:4 pick its input like channel one.
// - Amplifier two gain in bits 2:0; bit 3 reserved.
// - Modulator bit 7 disables input offset when one, enables when zero.
// - Modulator bit 6 enables high precision for both modulators.
// - Modulator bit 5 powers down modulator two.
// - Modulator bit 4 powers down modulator one; bits 3:0 reserved.
// - Every register resets to 0x00.
// - Undefined bits and addresses read back as zero.
// - Power bit 7 reduces modulator bias; bit 6 reserved.
// - Power bits 5:4 scale amplifier first bias current.
// - Power bit 3 reduces modulator coarse phase current.
// - Power bit 2 reduces amplifier first tail current.
// - Power bits 1:0 scale amplifier fifth bias current.
`timescale 1ns/100ps
`include "cfgrb_params.svh"
module cfgrb_top import cfgrb_pkg::*; (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,

    // Serial port
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,

    // Channel one amplifier
    output logic chan_one_amp_sleep_o,
    output logic chan_one_amp_precise_o,
    output logic [1:0] chan_one_input_select_o,
    output logic chan_one_input_a_o,
    output logic chan_one_input_b_o,
    output logic chan_one_termination_o,
    output logic chan_one_guard_en_o,
    output logic [2:0] chan_one_amp_scale_o,
    output logic chan_one_scale_reserved_o,

    // Channel two amplifier
    output logic chan_two_sleep_o,
    output logic chan_two_amp_precise_o,
    output logic [1:0] chan_two_input_select_o,
    output logic chan_two_input_a_o,
    output logic chan_two_input_b_o,
    output logic chan_two_termination_o,
    output logic [2:0] chan_two_amp_scale_o,
    output logic chan_two_scale_reserved_o,

    // Modulators
    output logic modulator_shift_off_o,
    output logic modulator_shift_en_o,
    output logic modulator_precise_o,
    output logic chan_two_mod_sleep_o,
    output logic chan_one_sleep_o,

    // Bias trims
    output logic modulator_bias_reduce_o,
    output logic [1:0] first_bias_scale_o,
    output logic coarse_phase_reduce_o,
    output logic first_tail_reduce_o,
    output logic [1:0] fifth_bias_scale_o
);

    logic [2:0] pins_clean;
    cfgrb_addr_t addr;
    logic wr_stb;
    cfgrb_byte_t wr_data;
    cfgrb_byte_t rd_data;

    cfgrb_byte_t amp1_r;
    cfgrb_byte_t amp2_r;
    cfgrb_byte_t mod_r;
    cfgrb_byte_t pwr_r;

    cfgrb_byte_t amp1_nxt;
    cfgrb_byte_t amp2_nxt;
    cfgrb_byte_t mod_nxt;
    cfgrb_byte_t pwr_nxt;

    logic any_wr_r;

    // Chip select idles high, so its synchroniser resets to one.
    cfgrb_pin_sync #(
        .RESET_LEVEL(3'h4)
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i({spi_cs_n_i, spi_sclk_i, spi_sdi_i}),
        .level_o(pins_clean)
    );

    // The serial clock is sampled, so it must stay well below a quarter of mclk.
    cfgrb_spi_frame u_frame (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cs_n_i(pins_clean[2]),
        .sclk_i(pins_clean[1]),
        .sdi_i(pins_clean[0]),
        .rd_data_i(rd_data),
        .addr_o(addr),
        .wr_stb_o(wr_stb),
        .wr_data_o(wr_data),
        .sdo_o(spi_sdo_o),
        .sdo_oe_o(spi_sdo_oe_o)
    );

    // Reserved bits are masked at write time so they can never read back as one.
    always_comb begin
        amp1_nxt = amp1_r;
        amp2_nxt = amp2_r;
        mod_nxt = mod_r;
        pwr_nxt = pwr_r;

        if (wr_stb) begin
            if (addr == `CFGRB_ADDR_AMP1) begin
                amp1_nxt = wr_data & `CFGRB_MASK_AMP1;
            end else if (addr == `CFGRB_ADDR_AMP2) begin
                amp2_nxt = wr_data & `CFGRB_MASK_AMP2;
            end else if (addr == `CFGRB_ADDR_MOD) begin
                mod_nxt = wr_data & `CFGRB_MASK_MOD;
            end else if (addr == `CFGRB_ADDR_PWR) begin
                pwr_nxt = wr_data & `CFGRB_MASK_PWR;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            amp1_r <= `CFGRB_RESET_VAL;
            amp2_r <= `CFGRB_RESET_VAL;
            mod_r <= `CFGRB_RESET_VAL;
            pwr_r <= `CFGRB_RESET_VAL;
        end else begin
            amp1_r <= amp1_nxt;
            amp2_r <= amp2_nxt;
            mod_r <= mod_nxt;
            pwr_r <= pwr_nxt;
        end
    end

    // Unmapped addresses, the identity slot among them, read as zero.
    always_comb begin
        if (addr == `CFGRB_ADDR_AMP1) begin
            rd_data = amp1_r;
        end else if (addr == `CFGRB_ADDR_AMP2) begin
            rd_data = amp2_r;
        end else if (addr == `CFGRB_ADDR_MOD) begin
            rd_data = mod_r;
        end else if (addr == `CFGRB_ADDR_PWR) begin
            rd_data = pwr_r;
        end else begin
            rd_data = 8'h00;
        end
    end

    // Raw fields come straight from the register flops.
    assign chan_one_amp_sleep_o = amp1_r[`CFGRB_AMP_SLEEP_BIT];
    assign chan_one_amp_precise_o = amp1_r[`CFGRB_AMP_PRECISE_BIT];
    assign chan_one_input_select_o = amp1_r[`CFGRB_SEL_HI:`CFGRB_SEL_LO];
    assign chan_one_amp_scale_o = amp1_r[`CFGRB_SCALE_HI:`CFGRB_SCALE_LO];

    assign chan_two_sleep_o = amp2_r[`CFGRB_AMP_SLEEP_BIT];
    assign chan_two_amp_precise_o = amp2_r[`CFGRB_AMP_PRECISE_BIT];
    assign chan_two_input_select_o = amp2_r[`CFGRB_SEL_HI:`CFGRB_SEL_LO];
    assign chan_two_amp_scale_o = amp2_r[`CFGRB_SCALE_HI:`CFGRB_SCALE_LO];

    assign modulator_shift_off_o = mod_r[`CFGRB_MOD_SHIFT_OFF_BIT];
    assign modulator_precise_o = mod_r[`CFGRB_MOD_PRECISE_BIT];
    assign chan_two_mod_sleep_o = mod_r[`CFGRB_MOD2_SLEEP_BIT];
    assign chan_one_sleep_o = mod_r[`CFGRB_MOD1_SLEEP_BIT];

    assign modulator_bias_reduce_o = pwr_r[`CFGRB_PWR_MOD_BIAS_BIT];
    assign first_bias_scale_o = pwr_r[`CFGRB_PWR_I1_HI:`CFGRB_PWR_I1_LO];
    assign coarse_phase_reduce_o = pwr_r[`CFGRB_PWR_COARSE_BIT];
    assign first_tail_reduce_o = pwr_r[`CFGRB_PWR_TAIL_BIT];
    assign fifth_bias_scale_o = pwr_r[`CFGRB_PWR_I5_HI:`CFGRB_PWR_I5_LO];

    // Decoded lines are flopped from the next values, so they never lag the raw fields.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            chan_one_input_a_o <= 1'b0;
            chan_one_input_b_o <= 1'b0;
            chan_one_termination_o <= 1'b1;
            chan_one_guard_en_o <= 1'b1;
            chan_one_scale_reserved_o <= 1'b0;
            chan_two_input_a_o <= 1'b0;
            chan_two_input_b_o <= 1'b0;
            chan_two_termination_o <= 1'b1;
            chan_two_scale_reserved_o <= 1'b0;
            modulator_shift_en_o <= 1'b1;
        end else begin
            chan_one_input_a_o <= amp1_nxt[`CFGRB_SEL_HI];
            chan_one_input_b_o <= amp1_nxt[`CFGRB_SEL_LO];
            chan_one_termination_o <= amp1_nxt[`CFGRB_SEL_HI:`CFGRB_SEL_LO] == `CFGRB_SEL_TERM;
            chan_one_guard_en_o <= ~amp1_nxt[`CFGRB_GUARD_OFF_BIT];
            chan_one_scale_reserved_o <= amp1_nxt[`CFGRB_SCALE_HI:`CFGRB_SCALE_LO] == `CFGRB_SCALE_RESERVED;
            chan_two_input_a_o <= amp2_nxt[`CFGRB_SEL_HI];
            chan_two_input_b_o <= amp2_nxt[`CFGRB_SEL_LO];
            chan_two_termination_o <= amp2_nxt[`CFGRB_SEL_HI:`CFGRB_SEL_LO] == `CFGRB_SEL_TERM;
            chan_two_scale_reserved_o <= amp2_nxt[`CFGRB_SCALE_HI:`CFGRB_SCALE_LO] == `CFGRB_SCALE_RESERVED;
            modulator_shift_en_o <= ~mod_nxt[`CFGRB_MOD_SHIFT_OFF_BIT];
        end
    end

    // Helper for the checks below: has any write landed since reset.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            any_wr_r <= 1'b0;
        end else if (wr_stb) begin
            any_wr_r <= 1'b1;
        end
    end

    AST_RESET_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
        !any_wr_r |-> (amp1_r == 8'h00 && amp2_r == 8'h00 && mod_r == 8'h00 && pwr_r == 8'h00))
        else $error("Register left its reset value without a write.");

    AST_AMP1_SLEEP: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_AMP1) |=> chan_one_amp_sleep_o == $past(wr_data[7]))
        else $error("Amplifier one sleep does not follow the written bit.");

    AST_AMP1_PRECISE: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_AMP1) |=> chan_one_amp_precise_o == $past(wr_data[6]))
        else $error("Amplifier one precision does not follow the written bit.");

    AST_AMP1_SELECT: assert property (@(posedge mclk_i) disable iff (rst_i)
        chan_one_termination_o == (chan_one_input_select_o == 2'h0)
        && chan_one_input_a_o == chan_one_input_select_o[1]
        && chan_one_input_b_o == chan_one_input_select_o[0])
        else $error("Channel one input decode disagrees with its select field.");

    AST_AMP1_GUARD: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_AMP1) |=> chan_one_guard_en_o == !$past(wr_data[3]))
        else $error("Guard enable does not invert the written bit.");

    AST_AMP1_SCALE: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_AMP1) |=> chan_one_amp_scale_o == $past(wr_data[2:0])
        && chan_one_scale_reserved_o == ($past(wr_data[2:0]) == 3'h7))
        else $error("Channel one gain field or reserved flag is wrong.");

    AST_AMP2_CTRL: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_AMP2) |=> chan_two_sleep_o == $past(wr_data[7])
        && chan_two_amp_precise_o == $past(wr_data[6]))
        else $error("Amplifier two sleep or precision is wrong.");

    AST_AMP2_SELECT: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_AMP2) |=> chan_two_input_select_o == $past(wr_data[5:4])
        && chan_two_termination_o == ($past(wr_data[5:4]) == 2'h0))
        else $error("Channel two input select is wrong.");

    AST_AMP2_RESERVED: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_AMP2) |=> amp2_r[3] == 1'b0
        && chan_two_amp_scale_o == $past(wr_data[2:0]))
        else $error("Channel two reserved bit stored or gain wrong.");

    AST_MOD_OFFSET: assert property (@(posedge mclk_i) disable iff (rst_i)
        modulator_shift_en_o != modulator_shift_off_o)
        else $error("Offset enable is not the inverse of the offset-off bit.");

    AST_MOD_PRECISE: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_MOD) |=> modulator_precise_o == $past(wr_data[6]))
        else $error("Modulator precision does not follow the written bit.");

    AST_MOD_SLEEP: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_MOD) |=> chan_two_mod_sleep_o == $past(wr_data[5])
        && chan_one_sleep_o == $past(wr_data[4]) && mod_r[3:0] == 4'h0)
        else $error("Modulator power down bits are wrong.");

    AST_READ_UNMAPPED: assert property (@(posedge mclk_i) disable iff (rst_i)
        (addr == 7'h00 || addr > 7'h04) |-> rd_data == 8'h00)
        else $error("Unmapped address does not read zero.");

    AST_PWR_FIELDS: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_PWR) |=> modulator_bias_reduce_o == $past(wr_data[7])
        && pwr_r[6] == 1'b0 && first_bias_scale_o == $past(wr_data[5:4]))
        else $error("Power register upper fields are wrong.");

    AST_PWR_LOW: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_PWR) |=> coarse_phase_reduce_o == $past(wr_data[3])
        && first_tail_reduce_o == $past(wr_data[2]) && fifth_bias_scale_o == $past(wr_data[1:0]))
        else $error("Power register lower fields are wrong.");

    AST_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        !wr_stb |=> $stable(amp1_r) && $stable(amp2_r) && $stable(mod_r) && $stable(pwr_r))
        else $error("Register changed without a write.");

    AST_RESET_DECODE: assert property (@(posedge mclk_i) disable iff (rst_i)
        !any_wr_r
        |-> chan_one_termination_o
        && chan_two_termination_o
        && chan_one_guard_en_o
        && modulator_shift_en_o)
        else $error("Decoded lines not at rest before a write.");

    AST_AMP1_WR_SELECT: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_AMP1)
        |=> chan_one_input_select_o == $past(wr_data[5:4])
        && chan_one_input_a_o == $past(wr_data[5])
        && chan_one_input_b_o == $past(wr_data[4]))
        else $error("Channel one input lines are wrong.");

    AST_AMP1_GUARD_LVL: assert property (@(posedge mclk_i) disable iff (rst_i)
        chan_one_guard_en_o == !amp1_r[`CFGRB_GUARD_OFF_BIT]
        && chan_one_scale_reserved_o == (chan_one_amp_scale_o == 3'h7))
        else $error("Channel one guard or gain flag is wrong.");

    AST_AMP2_DECODE: assert property (@(posedge mclk_i) disable iff (rst_i)
        chan_two_input_a_o == chan_two_input_select_o[1]
        && chan_two_input_b_o == chan_two_input_select_o[0]
        && chan_two_termination_o == (chan_two_input_select_o == 2'h0))
        else $error("Channel two input decode is wrong.");

    AST_AMP2_SCALE_FLAG: assert property (@(posedge mclk_i) disable iff (rst_i)
        chan_two_scale_reserved_o == (chan_two_amp_scale_o == 3'h7))
        else $error("Channel two gain flag is wrong.");

    AST_MOD_SHIFT_WR: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_MOD)
        |=> modulator_shift_off_o == $past(wr_data[7])
        && modulator_shift_en_o == !$past(wr_data[7]))
        else $error("Offset lines are wrong.");

    AST_READBACK: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && addr == `CFGRB_ADDR_AMP1)
        |=> rd_data == $past(wr_data))
        else $error("Read data is not the byte written.");

    AST_UNMAPPED_WR: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wr_stb && (addr == 7'h00 || addr > `CFGRB_ADDR_PWR))
        |=> $stable(amp1_r)
        && $stable(amp2_r)
        && $stable(mod_r)
        && $stable(pwr_r))
        else $error("Unmapped write changed a register.");

    AST_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
        mod_r[3:0] == 4'h0
        && amp2_r[`CFGRB_GUARD_OFF_BIT] == 1'b0
        && pwr_r[6] == 1'b0)
        else $error("A reserved bit is held as one.");
endmodule

// ### tb/cfgrb_host_model.sv
// Host controller model that drives frames on the serial port of the register bank.
`timescale 1ns/100ps
module cfgrb_host_model #(
    parameter int HALF = 8
) (
    input wire logic mclk_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    logic busy = 1'b0;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    // Outside frames the data line toggles, so a design that samples it then cannot match by luck.
    always @(posedge mclk_i) begin
        if (!busy) begin
            sdi_o <= ~sdi_o;
        end
    end
    // Sends nbits of word MSB first; the read byte is taken on rises 9 to 16.
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        @(posedge mclk_i);
        busy = 1'b1;
        cs_n_o <= 1'b0;
        repeat (HALF) @(posedge mclk_i);
        for (i = 0; i < nbits; i++) begin
            sdi_o <= word[15 - i];
            repeat (HALF) @(posedge mclk_i);
            if (i >= 8) rd = {rd[6:0], sdo_i};
            sclk_o <= 1'b1;
            repeat (HALF) @(posedge mclk_i);
            sclk_o <= 1'b0;
        end
        repeat (HALF) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        busy = 1'b0;
        repeat (HALF) @(posedge mclk_i);
    endtask
endmodule

// ### tb/tb.sv
// Self-checking bench of the configuration register bank.
`timescale 1ns/100ps
`include "cfgrb_params.svh"
module tb;
    import cfgrb_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sclk, sdi, sdo, sdo_oe;
    wire [34:0] outs;
    cfgrb_byte_t regs [0:7];
    logic [31:0] seed = 32'h2063;
    int fails = 0;
    int n_compared = 0;
    always #10 mclk = ~mclk;
    cfgrb_host_model host (.mclk_i(mclk), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo));
    cfgrb_top dut (.mclk_i(mclk), .rst_i(rst), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_sdi_i(sdi),
        .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .chan_one_amp_sleep_o(outs[34]), .chan_one_amp_precise_o(outs[33]),
        .chan_one_input_select_o(outs[32:31]), .chan_one_input_a_o(outs[30]), .chan_one_input_b_o(outs[29]),
        .chan_one_termination_o(outs[28]), .chan_one_guard_en_o(outs[27]), .chan_one_amp_scale_o(outs[26:24]),
        .chan_one_scale_reserved_o(outs[23]), .chan_two_sleep_o(outs[22]), .chan_two_amp_precise_o(outs[21]),
        .chan_two_input_select_o(outs[20:19]), .chan_two_input_a_o(outs[18]), .chan_two_input_b_o(outs[17]),
        .chan_two_termination_o(outs[16]), .chan_two_amp_scale_o(outs[15:13]), .chan_two_scale_reserved_o(outs[12]),
        .modulator_shift_off_o(outs[11]), .modulator_shift_en_o(outs[10]), .modulator_precise_o(outs[9]),
        .chan_two_mod_sleep_o(outs[8]), .chan_one_sleep_o(outs[7]), .modulator_bias_reduce_o(outs[6]),
        .first_bias_scale_o(outs[5:4]), .coarse_phase_reduce_o(outs[3]), .first_tail_reduce_o(outs[2]),
        .fifth_bias_scale_o(outs[1:0]));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [34:0] dec(input cfgrb_byte_t a, input cfgrb_byte_t b, input cfgrb_byte_t m,
        input cfgrb_byte_t p);
        dec = {a[7], a[6], a[5:4], a[5], a[4], a[5:4] == 2'h0, ~a[3], a[2:0], a[2:0] == 3'h7,
            b[7], b[6], b[5:4], b[5], b[4], b[5:4] == 2'h0, b[2:0], b[2:0] == 3'h7,
            m[7], ~m[7], m[6], m[5], m[4], p[7], p[5:4], p[3], p[2], p[1:0]};
    endfunction
    function automatic cfgrb_byte_t mask(input cfgrb_addr_t a);
        case (a)
            `CFGRB_ADDR_AMP1: mask = `CFGRB_MASK_AMP1;
            `CFGRB_ADDR_AMP2: mask = `CFGRB_MASK_AMP2;
            `CFGRB_ADDR_MOD: mask = `CFGRB_MASK_MOD;
            `CFGRB_ADDR_PWR: mask = `CFGRB_MASK_PWR;
            default: mask = 8'h00;
        endcase
    endfunction
    task automatic chk8(input string what, input cfgrb_byte_t exp, input cfgrb_byte_t got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_outs();
        logic [36:0] exp;
        exp = {dec(regs[1], regs[2], regs[3], regs[4]), 2'h0};
        n_compared++;
        if ({outs, sdo, sdo_oe} !== exp) begin
            fails++;
            $display("[FAIL] control outputs expected %h seen %h", exp, {outs, sdo, sdo_oe});
        end
    endtask
    task automatic wr(input cfgrb_addr_t a, input cfgrb_byte_t d);
        cfgrb_byte_t junk;
        host.xfer({1'b0, a, d}, 16, junk);
        if (mask(a) != 8'h00) regs[a[2:0]] = d & mask(a);
    endtask
    task automatic rd_chk(input cfgrb_addr_t a);
        cfgrb_byte_t got;
        host.xfer({1'b1, a, 8'h00}, 16, got);
        chk8($sformatf("read of %h", a), (mask(a) != 8'h00) ? regs[a[2:0]] : 8'h00, got);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // The span allows about three times the expected length of the run.
    initial begin
        repeat (80000) @(posedge mclk);
        fails++;
        close_out();
    end
    initial begin
        int i;
        cfgrb_addr_t a;
        cfgrb_byte_t junk;
        for (i = 0; i < 8; i++) regs[i] = 8'h00;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        chk_outs();
        for (i = 0; i < 5; i++) rd_chk(cfgrb_addr_t'(i));
        for (i = 1; i < 5; i++) begin
            wr(cfgrb_addr_t'(i), 8'hFF);
            chk_outs();
            rd_chk(cfgrb_addr_t'(i));
        end
        for (i = 0; i < 8; i++) begin
            wr(7'h01, {2'h0, i[1:0], i[0], i[2:0]});
            wr(7'h02, {2'h0, i[1:0], 1'b1, i[2:0]});
            wr(7'h04, {2'h0, i[1:0], 2'h0, i[1:0]});
            chk_outs();
        end
        for (i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            a = cfgrb_addr_t'(seed[1:0]) + 7'h01;
            wr(a, seed[15:8]);
            chk_outs();
            rd_chk(a);
        end
        wr(7'h00, 8'hFF);
        wr(7'h05, 8'hFF);
        wr(7'h7F, 8'hA5);
        chk_outs();
        rd_chk(7'h05);
        rd_chk(7'h7F);
        host.xfer({1'b0, 7'h04, 8'h55}, 10, junk);
        host.xfer({1'b0, 7'h01, 8'h3C}, 15, junk);
        chk_outs();
        rd_chk(7'h04);
        wr(7'h03, 8'h40);
        chk_outs();
        wr(7'h03, 8'h30);
        chk_outs();
        wr(7'h01, 8'h80);
        wr(7'h02, 8'h80);
        chk_outs();
        wr(7'h04, 8'h8F);
        chk_outs();
        rd_chk(7'h04);
        wr(7'h04, 8'h00);
        wr(7'h03, 8'hF0);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) regs[i] = 8'h00;
        repeat (6) @(posedge mclk);
        chk_outs();
        for (i = 1; i < 5; i++) rd_chk(cfgrb_addr_t'(i));
        close_out();
    end
endmodule
